//--- slpc_status_led.sv
// module: status led pattern generator for power and per-channel traffic leds
`timescale 1ns/100ps
//
// Contract
// - one power led, one traffic led per channel
// - off darkens both colours, on holds colour
// - flash gives one short pulse per event
// - slow blink: equal on and off phases
// - fast blink: equal phases, faster than slow
// - waver alternates two colours at blink rates
// - running lights one colour at a time
// - interface mode normal: power steady green
// - unconfigured usb: power slow yellow, traffic off
// - config error: slow waver on all leds; low power: power slow waver, traffic slow yellow
// - low supply raises the power problem indication in interface mode only
// - traffic: idle off, yellow frame, red error
// - error passive channel fast blinks red
// - overrun latches red until bus off
// - firmware update: all traffic fast blink yellow
// - configuration software link shows running pattern
// - disk activity: power green, traffic fast yellow
// - logger faults: common traffic pattern per fault
// - logger power green: armed, active, stopped
// - logger traffic shows bus status as interface
// - running script may override any led
// - script load failure shows configuration fault
module slpc_status_led #(
   parameter int FLASH_CYC = slpc_pkg::FLASH_CYC,  // flash length in cycles
   parameter int SLOW_CYC  = slpc_pkg::SLOW_CYC,   // slow half period in cycles
   parameter int FAST_CYC  = slpc_pkg::FAST_CYC,   // fast half period, below slow
   parameter int RUN_CYC   = slpc_pkg::RUN_CYC     // running step in cycles
) (
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   input  wire slpc_pkg::slpc_mode_t   mode,
   input  wire slpc_pkg::slpc_ch_evt_t ch_evt,
   input  wire slpc_pkg::slpc_script_t script,
   output      slpc_pkg::slpc_leds_t   leds
);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------

   // colour pair for one dual led: bit0 first colour, bit1 second colour
   function automatic logic [1:0] slpc_dual(
      input slpc_pkg::slpc_pat_t pat,
      input logic                swap,
      input logic                slow,
      input logic                fast,
      input logic                flash
   );
      logic [1:0] r;
      r = 2'h0;
      case (pat)
         slpc_pkg::PAT_OFF:        r = 2'h0;
         slpc_pkg::PAT_ON:         r = 2'h1;
         slpc_pkg::PAT_FLASH:      r = {1'b0, flash};
         slpc_pkg::PAT_SLOW_BLINK: r = {1'b0, slow};
         slpc_pkg::PAT_FAST_BLINK: r = {1'b0, fast};
         slpc_pkg::PAT_SLOW_WAVER: r = slow ? 2'h1 : 2'h2;
         slpc_pkg::PAT_FAST_WAVER: r = fast ? 2'h1 : 2'h2;
         default:                  r = 2'h0;
      endcase
      return swap ? {r[0], r[1]} : r;
   endfunction

   // -----------------------------------------------------------------
   // rate timers
   // -----------------------------------------------------------------
   logic [slpc_pkg::CNT_W-1:0]  slow_cnt;       // slow half period counter
   logic [slpc_pkg::CNT_W-1:0]  fast_cnt;       // fast half period counter
   logic [slpc_pkg::CNT_W-1:0]  run_cnt;        // running dwell counter
   logic                        slow_ph;        // slow phase, on half when high
   logic                        fast_ph;        // fast phase, on half when high
   logic [slpc_pkg::STEP_W-1:0] run_step;       // running step index
   logic [slpc_pkg::CNT_W-1:0]  next_slow_cnt;
   logic [slpc_pkg::CNT_W-1:0]  next_fast_cnt;
   logic [slpc_pkg::CNT_W-1:0]  next_run_cnt;
   logic                        next_slow_ph;
   logic                        next_fast_ph;
   logic [slpc_pkg::STEP_W-1:0] next_run_step;

   // free running counters; each phase toggles after a full half period,
   // so on and off halves are equal by construction
   always_comb begin
      next_slow_cnt = slow_cnt + 1'b1;
      next_slow_ph  = slow_ph;
      next_fast_cnt = fast_cnt + 1'b1;
      next_fast_ph  = fast_ph;
      next_run_cnt  = run_cnt + 1'b1;
      next_run_step = run_step;
      // slow half period ends
      if (slow_cnt == slpc_pkg::CNT_W'(SLOW_CYC - 1)) begin
         next_slow_cnt = '0;
         next_slow_ph  = ~slow_ph;
      end
      // fast half period ends
      if (fast_cnt == slpc_pkg::CNT_W'(FAST_CYC - 1)) begin
         next_fast_cnt = '0;
         next_fast_ph  = ~fast_ph;
      end
      // running dwell ends, step wraps after the last traffic red
      if (run_cnt == slpc_pkg::CNT_W'(RUN_CYC - 1)) begin
         next_run_cnt = '0;
         if (run_step == slpc_pkg::STEP_W'(slpc_pkg::RUN_STEPS - 1)) begin
            next_run_step = '0;
         end else begin
            next_run_step = run_step + 1'b1;
         end
      end
   end

   // timer registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         slow_cnt <= '0;
         fast_cnt <= '0;
         run_cnt  <= '0;
         slow_ph  <= 1'b1;
         fast_ph  <= 1'b1;
         run_step <= '0;
      end else begin
         slow_cnt <= next_slow_cnt;
         fast_cnt <= next_fast_cnt;
         run_cnt  <= next_run_cnt;
         slow_ph  <= next_slow_ph;
         fast_ph  <= next_fast_ph;
         run_step <= next_run_step;
      end
   end

   // -----------------------------------------------------------------
   // per channel bus status
   // -----------------------------------------------------------------
   slpc_pkg::slpc_pat_t      ch_pat  [slpc_pkg::NUM_CH];  // pattern of each channel
   logic [slpc_pkg::NUM_CH-1:0] ch_red;                  // channel pattern uses red
   logic [slpc_pkg::NUM_CH-1:0] ch_flash;                // flash pulse running

   for (genvar c = 0; c < slpc_pkg::NUM_CH; c++) begin : g_ch
      logic [slpc_pkg::CNT_W-1:0] flash_cnt;        // remaining flash cycles
      logic                       flash_red;        // flash colour is red
      logic                       ovr_latch;        // overrun held red
      logic [slpc_pkg::CNT_W-1:0] next_flash_cnt;
      logic                       next_flash_red;
      logic                       next_ovr_latch;

      // a new event restarts the flash; error frames flash red
      always_comb begin
         next_flash_cnt = flash_cnt;
         next_flash_red = flash_red;
         next_ovr_latch = ovr_latch;
         if (ch_evt.err_frame_evt[c]) begin
            next_flash_cnt = slpc_pkg::CNT_W'(FLASH_CYC);
            next_flash_red = 1'b1;
         end else if (ch_evt.frame_evt[c]) begin
            next_flash_cnt = slpc_pkg::CNT_W'(FLASH_CYC);
            next_flash_red = 1'b0;
         end else if (flash_cnt != '0) begin
            next_flash_cnt = flash_cnt - 1'b1;
         end
         // overrun sets, bus off clears; the set wins on a tie
         if (ch_evt.overrun_evt[c]) begin
            next_ovr_latch = 1'b1;
         end else if (ch_evt.bus_off[c]) begin
            next_ovr_latch = 1'b0;
         end
      end

      // channel registers
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            flash_cnt <= '0;
            flash_red <= 1'b0;
            ovr_latch <= 1'b0;
         end else begin
            flash_cnt <= next_flash_cnt;
            flash_red <= next_flash_red;
            ovr_latch <= next_ovr_latch;
         end
      end

      // status priority: overrun, error passive, flash, idle
      always_comb begin
         ch_flash[c] = (flash_cnt != '0);
         ch_red[c]   = 1'b1;
         if (ovr_latch) begin
            ch_pat[c] = slpc_pkg::PAT_ON;
         end else if (ch_evt.err_passive[c]) begin
            ch_pat[c] = slpc_pkg::PAT_FAST_BLINK;
         end else if (flash_cnt != '0) begin
            ch_pat[c] = slpc_pkg::PAT_FLASH;
            ch_red[c] = flash_red;
         end else begin
            ch_pat[c] = slpc_pkg::PAT_OFF;
            ch_red[c] = 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // mode selection
   // -----------------------------------------------------------------
   slpc_pkg::slpc_pat_t power_pat;     // power led pattern
   logic                power_swap;    // power pattern starts with yellow
   slpc_pkg::slpc_pat_t all_pat;       // common traffic pattern
   logic                all_red;       // common traffic pattern starts with red
   logic                all_use;       // common pattern replaces bus status

   // device wide indication, highest priority first
   always_comb begin
      power_pat  = slpc_pkg::PAT_ON;
      power_swap = 1'b0;
      all_pat    = slpc_pkg::PAT_OFF;
      all_red    = 1'b0;
      all_use    = 1'b0;
      if (mode.tool_link) begin
         power_pat = slpc_pkg::PAT_RUNNING;
         all_pat   = slpc_pkg::PAT_RUNNING;
         all_use   = 1'b1;
      end else if (mode.disk_busy) begin
         all_pat = slpc_pkg::PAT_FAST_BLINK;
         all_use = 1'b1;
      end else if (mode.iface_mode) begin
         if (!mode.usb_configured) begin
            power_pat  = slpc_pkg::PAT_SLOW_BLINK;
            power_swap = 1'b1;
            all_use    = 1'b1;
         end else if (mode.fw_cfg_err) begin
            power_pat = slpc_pkg::PAT_SLOW_WAVER;
            all_pat   = slpc_pkg::PAT_SLOW_WAVER;
            all_use   = 1'b1;
         end else if (mode.supply_low) begin
            power_pat = slpc_pkg::PAT_SLOW_WAVER;
            all_pat   = slpc_pkg::PAT_SLOW_BLINK;
            all_use   = 1'b1;
         end else if (mode.fw_update) begin
            all_pat = slpc_pkg::PAT_FAST_BLINK;
            all_use = 1'b1;
         end
         // otherwise power stays steady green
      end else if (mode.log_fw_hw_err) begin
         power_pat = slpc_pkg::PAT_FAST_WAVER;
         all_pat   = slpc_pkg::PAT_FAST_WAVER;
         all_use   = 1'b1;
      end else if (mode.log_batt_fault) begin
         power_pat = slpc_pkg::PAT_FAST_WAVER;
         all_pat   = slpc_pkg::PAT_SLOW_WAVER;
         all_use   = 1'b1;
      end else if (mode.log_disk_err) begin
         power_swap = 1'b1;
         all_pat    = slpc_pkg::PAT_SLOW_BLINK;
         all_red    = 1'b1;
         all_use    = 1'b1;
      end else if (mode.log_cfg_bad || mode.script_load_fail) begin
         power_swap = 1'b1;
         all_pat    = slpc_pkg::PAT_FAST_BLINK;
         all_red    = 1'b1;
         all_use    = 1'b1;
      end else if (mode.log_active) begin
         power_pat = slpc_pkg::PAT_FAST_BLINK;
      end else if (mode.log_trig_stop) begin
         power_pat = slpc_pkg::PAT_SLOW_BLINK;
      end
      // logger armed keeps power green on, traffic shows bus
   end

   // -----------------------------------------------------------------
   // output composition
   // -----------------------------------------------------------------
   slpc_pkg::slpc_leds_t next_leds;  // colour drive for the next cycle

   // resolve patterns to colours, then apply script overrides
   always_comb begin
      logic [1:0] pair;
      pair      = 2'h0;
      next_leds = slpc_pkg::LEDS_RST;
      // power led, green first unless swapped to yellow
      if (power_pat == slpc_pkg::PAT_RUNNING) begin
         next_leds.power_green  = (run_step == slpc_pkg::STEP_W'(0));
         next_leds.power_yellow = (run_step == slpc_pkg::STEP_W'(1));
      end else begin
         pair = slpc_dual(power_pat, power_swap, slow_ph, fast_ph, 1'b0);
         next_leds.power_green  = pair[0];
         next_leds.power_yellow = pair[1];
      end
      // traffic leds, yellow first unless the pattern starts red
      for (int c = 0; c < slpc_pkg::NUM_CH; c++) begin
         if (all_use && all_pat == slpc_pkg::PAT_RUNNING) begin
            pair = {run_step == slpc_pkg::STEP_W'(3 + 2 * c),
                    run_step == slpc_pkg::STEP_W'(2 + 2 * c)};
         end else if (all_use) begin
            pair = slpc_dual(all_pat, all_red, slow_ph, fast_ph, 1'b0);
         end else begin
            pair = slpc_dual(ch_pat[c], ch_red[c], slow_ph, fast_ph,
                             ch_flash[c]);
         end
         next_leds.traffic_yellow[c] = pair[0];
         next_leds.traffic_red[c]    = pair[1];
         if (script.traffic_en[c]) begin
            next_leds.traffic_yellow[c] = script.value.traffic_yellow[c];
            next_leds.traffic_red[c]    = script.value.traffic_red[c];
         end
      end
      if (script.power_en) begin
         next_leds.power_green  = script.value.power_green;
         next_leds.power_yellow = script.value.power_yellow;
      end
   end

   // led drive register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         leds <= slpc_pkg::LEDS_RST;
      end else begin
         leds <= next_leds;
      end
   end

endmodule

//--- slpc_pkg.sv
// package: constants, pattern codes and carrier structs of the status led controller
package slpc_pkg;

   // -----------------------------------------------------------------
   // sizes
   // -----------------------------------------------------------------
   localparam int NUM_CH    = 5;                 // traffic leds, one per bus channel
   localparam int RUN_STEPS = 2 + 2 * NUM_CH;    // colours visited by the running pattern
   localparam int STEP_W    = 4;                 // width of the running step index
   localparam int CNT_W     = 24;                // width of every timing counter

   // -----------------------------------------------------------------
   // timing: times in ms, counts derived from the 20 MHz clock
   // -----------------------------------------------------------------
   localparam int CLK_HZ       = 20_000_000;     // mclk rate
   localparam int CYC_PER_MS   = CLK_HZ / 1000;  // cycles in one millisecond
   localparam int FLASH_MS     = 20;             // one flash pulse
   localparam int SLOW_HALF_MS = 500;            // half period of slow blink / waver
   localparam int FAST_HALF_MS = 125;            // half period of fast blink / waver
   localparam int RUN_STEP_MS  = 150;            // dwell of each running step
   localparam int FLASH_CYC    = FLASH_MS * CYC_PER_MS;
   localparam int SLOW_CYC     = SLOW_HALF_MS * CYC_PER_MS;
   localparam int FAST_CYC     = FAST_HALF_MS * CYC_PER_MS;
   localparam int RUN_CYC      = RUN_STEP_MS * CYC_PER_MS;

   // -----------------------------------------------------------------
   // pattern codes and carriers
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      PAT_OFF, PAT_FLASH, PAT_SLOW_BLINK, PAT_FAST_BLINK,
      PAT_ON, PAT_SLOW_WAVER, PAT_FAST_WAVER, PAT_RUNNING
   } slpc_pat_t;

   // device mode and status conditions, levels
   typedef struct packed {
      logic iface_mode;        // 1 interface mode, 0 logger mode
      logic usb_configured;    // host has configured the usb device
      logic fw_cfg_err;        // firmware configuration error
      logic supply_low;        // low supply detected
      logic fw_update;         // firmware update in progress
      logic tool_link;         // configuration software talking to device
      logic disk_busy;         // disk activity under configuration software
      logic log_fw_hw_err;     // logger firmware or hardware error
      logic log_batt_fault;    // logger battery fault
      logic log_disk_err;      // disk full or disk error
      logic log_cfg_bad;       // configuration missing or corrupt
      logic script_load_fail;  // configured script failed to load and start
      logic log_active;        // logging active
      logic log_trig_stop;     // logging stopped by a trigger
   } slpc_mode_t;

   // per channel bus events (pulses) and states (levels)
   typedef struct packed {
      logic [NUM_CH-1:0] frame_evt;      // frame received or sent, pulse
      logic [NUM_CH-1:0] err_frame_evt;  // error frame received, pulse
      logic [NUM_CH-1:0] err_passive;    // channel error passive, level
      logic [NUM_CH-1:0] overrun_evt;    // overrun, pulse
      logic [NUM_CH-1:0] bus_off;        // channel bus off, level
   } slpc_ch_evt_t;

   // led colour drive, active high
   typedef struct packed {
      logic              power_green;
      logic              power_yellow;
      logic [NUM_CH-1:0] traffic_yellow;
      logic [NUM_CH-1:0] traffic_red;
   } slpc_leds_t;

   // script override: per led enable plus the colours to show
   typedef struct packed {
      logic              power_en;
      logic [NUM_CH-1:0] traffic_en;
      slpc_leds_t        value;
   } slpc_script_t;

   localparam slpc_leds_t LEDS_RST = '0;         // all colours dark at reset

endpackage

//--- slpc_led_viewer.sv
// model of a viewer: lit and dark run lengths of one led colour
`timescale 1ns/100ps
module slpc_led_viewer (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic lamp,
   output      logic run_done,
   output      int   run_len
);
   logic last;   // lamp at the previous edge
   int   cnt;    // edges in the current run

   // a lamp change ends a run and publishes its length
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         last     <= 1'b0;
         cnt      <= 0;
         run_done <= 1'b0;
         run_len  <= 0;
      end else begin
         last     <= lamp;
         run_done <= (lamp != last);
         if (lamp != last) begin
            run_len <= cnt;
            cnt     <= 1;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule

//--- slpc_status_led_checker.sv
// checker: properties on the ports of the status led controller
`timescale 1ns/100ps
module slpc_status_led_checker #(
   parameter int FLASH_CYC = 4   // flash length in cycles
) (
   input wire logic                   mclk,
   input wire logic                   rst_n,
   input wire slpc_pkg::slpc_mode_t   mode,
   input wire slpc_pkg::slpc_ch_evt_t ch_evt,
   input wire slpc_pkg::slpc_script_t script,
   input wire slpc_pkg::slpc_leds_t   leds
);
   // ----------------------------------------------------------------
   // helper state: channel 0 flash and overrun mirror
   // ----------------------------------------------------------------
   logic iface_ok;                 // interface mode, power steady green
   logic quiet0;                   // channel 0 shows plain bus status
   logic no_script;                // no override on any led
   logic hit0;                     // flash event on channel 0
   logic lit0;                     // channel 0 flash running
   logic ovr0,   next_ovr0;        // overrun latch of channel 0
   logic fl_red, next_fl_red;      // colour of the running flash
   int   fl_cnt, next_fl_cnt;      // flash cycles left

   // next values of the mirror
   always_comb begin
      iface_ok    = mode.iface_mode && mode.usb_configured && !mode.fw_cfg_err
                    && !mode.supply_low && !mode.tool_link && !mode.disk_busy;
      quiet0      = iface_ok && !mode.fw_update && !script.traffic_en[0];
      no_script   = !script.power_en && (script.traffic_en == '0);
      hit0        = ch_evt.frame_evt[0] || ch_evt.err_frame_evt[0];
      lit0        = (fl_cnt != 0);
      next_ovr0   = ch_evt.overrun_evt[0] || (ovr0 && !ch_evt.bus_off[0]);
      next_fl_cnt = hit0 ? FLASH_CYC : ((fl_cnt > 0) ? fl_cnt - 1 : 0);
      next_fl_red = hit0 ? ch_evt.err_frame_evt[0] : fl_red;
   end

   // register the mirror
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ovr0   <= 1'b0;
         fl_cnt <= 0;
         fl_red <= 1'b0;
      end else begin
         ovr0   <= next_ovr0;
         fl_cnt <= next_fl_cnt;
         fl_red <= next_fl_red;
      end
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // overrun, then one quiet cycle while the latch lands
   sequence s_ovr_arm;
      ch_evt.overrun_evt[0] && quiet0 ##1 quiet0 && !ch_evt.bus_off[0];
   endsequence
   // channel 0 free of higher bus status
   sequence s_flash_gate;
      quiet0 && !ch_evt.err_passive[0] && !ovr0;
   endsequence

   a_flash_traffic: assert property (s_flash_gate |=>
      leds.traffic_yellow[0] == $past(lit0 && !fl_red)
      && leds.traffic_red[0] == $past(lit0 && fl_red))
      else $error("channel 0 flash wrong");
   a_overrun_set: assert property (s_ovr_arm |=> leds.traffic_red[0])
      else $error("overrun did not light red");
   a_overrun_hold: assert property (quiet0 && ovr0 |=> leds.traffic_red[0] && !leds.traffic_yellow[0])
      else $error("overrun red not held");
   a_iface_green: assert property (iface_ok && !script.power_en |=> leds[11:10] == 2'h2)
      else $error("power not steady green");
   a_unconfig_dark: assert property (mode.iface_mode && !mode.usb_configured && !mode.tool_link
      && !mode.disk_busy && no_script |=> !leds.power_green && leds[9:0] == '0)
      else $error("unconfigured pattern wrong");
   a_waver_both: assert property (mode.iface_mode && mode.usb_configured && mode.fw_cfg_err
      && !mode.tool_link && !mode.disk_busy && no_script
      |=> ^leds[11:10] && &(leds[9:5] ^ leds[4:0]))
      else $error("waver went dark");
   a_update_common: assert property (iface_ok && mode.fw_update && no_script |=> leds.power_green
      && leds[4:0] == '0 && (leds[9:5] == '0 || &leds[9:5]))
      else $error("update pattern wrong");
   a_running_single: assert property (mode.tool_link && no_script |=> $onehot(leds))
      else $error("running lights not single");
   a_script_power: assert property (script.power_en |=>
      leds[11:10] == $past(script.value[11:10]))
      else $error("script override ignored");
   a_cfg_fault: assert property (!mode.iface_mode && (mode.log_cfg_bad || mode.script_load_fail)
      && !mode.log_fw_hw_err && !mode.log_batt_fault && !mode.log_disk_err && !mode.tool_link
      && !mode.disk_busy && no_script |=> leds[11:10] == 2'h1
      && leds[9:5] == '0 && (leds[4:0] == '0 || &leds[4:0]))
      else $error("config fault pattern wrong");
endmodule

bind slpc_status_led slpc_status_led_checker #(.FLASH_CYC(FLASH_CYC)) u_chk (
   .mclk(mclk), .rst_n(rst_n), .mode(mode), .ch_evt(ch_evt), .script(script), .leds(leds));

//--- tb.sv
// testbench: pattern, timing and priority checks of the status led controller
`timescale 1ns/100ps
module tb;
   localparam int FL = 4;    // flash length used here
   localparam int SL = 16;   // slow half period
   localparam int FA = 4;    // fast half period
   localparam int RU = 8;    // running step dwell
   logic                   mclk;        // system clock
   logic                   rst_n;       // active low reset
   slpc_pkg::slpc_mode_t   mode;        // mode and status levels
   slpc_pkg::slpc_ch_evt_t ch_evt;      // channel events
   slpc_pkg::slpc_script_t script;      // script override
   slpc_pkg::slpc_leds_t   leds;        // led drive
   logic [11:0]            led_bits;    // leds as plain bits
   int                     probe;       // bit watched by the viewer
   logic                   run_done;    // viewer saw a run end
   int                     run_len;     // length of that run
   int                     n_fail;      // mismatches
   int                     num_checks;  // comparisons
   int                     i;           // table index
   // blink table: mode, watched bit, expected half period
   logic [13:0] cm [15] = '{14'h2000, 14'h3800, 14'h3800, 14'h3400, 14'h3200, 14'h3080,
      14'h0040, 14'h0040, 14'h0020, 14'h0020, 14'h0010, 14'h0008, 14'h0004, 14'h0002, 14'h0001};
   int cb [15] = '{10, 11, 0, 9, 5, 7, 11, 0, 11, 2, 4, 1, 3, 11, 11};
   int ch [15] = '{SL, SL, SL, SL, FA, FA, FA, FA, FA, SL, SL, FA, FA, FA, SL};
   // steady table: mode and expected power colours
   logic [13:0] sm [6] = '{14'h3000, 14'h0000, 14'h0010, 14'h0008, 14'h3080, 14'h3200};
   logic [1:0]  sp [6] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2};

   assign led_bits = leds;

   slpc_status_led #(.FLASH_CYC(FL), .SLOW_CYC(SL), .FAST_CYC(FA), .RUN_CYC(RU)) DUT (
      .mclk(mclk), .rst_n(rst_n), .mode(mode), .ch_evt(ch_evt), .script(script), .leds(leds));
   slpc_led_viewer u_view (
      .mclk(mclk), .rst_n(rst_n), .lamp(led_bits[probe]), .run_done(run_done), .run_len(run_len));

   // clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // compare and count
   task chk(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // apply a mode at a rising edge
   task set_mode(input logic [13:0] m);
      @(posedge mclk);
      mode <= slpc_pkg::slpc_mode_t'(m);
   endtask

   // skip three runs cut by the switch, check two against the half period
   task measure(input int b, input int half);
      int k;
      int t;
      probe = b;
      for (k = 0; k < 5; k++) begin
         t = 0;
         do begin
            @(posedge mclk);
            t++;
         end while (!run_done && t < 100);
         if (k >= 3) chk((t < 100) ? 12'(run_len) : 12'h000, 12'(half));
      end
   endtask

   // one frame or error frame: count lit cycles per colour
   task flash(input int c, input logic err);
      int lit;
      int bad;
      @(posedge mclk);
      if (err) ch_evt.err_frame_evt[c] <= 1'b1;
      else ch_evt.frame_evt[c] <= 1'b1;
      @(posedge mclk);
      {ch_evt.frame_evt, ch_evt.err_frame_evt} <= '0;
      lit = 0;
      bad = 0;
      repeat (12) begin
         @(posedge mclk);
         lit += led_bits[err ? c : 5 + c];
         bad += led_bits[err ? 5 + c : c];
      end
      chk(12'(lit), 12'(FL));
      chk(12'(bad), 12'h000);
   endtask

   // colour bit lit at a given running step
   function automatic int step_bit(input int s);
      if (s < 2) return 11 - s;
      return (s % 2 == 0) ? 5 + (s - 2) / 2 : (s - 3) / 2;
   endfunction

   // verdict and end of run
   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // watchdog against a hang
   initial begin
      repeat (30000) @(posedge mclk);
      n_fail++;
      print_verdict;
   end

   // main sequence
   initial begin : main
      int lit;
      int d;
      int s;
      logic [11:0] cur;
      mode = '0;
      ch_evt = '0;
      script = '0;
      rst_n = 1'b0;
      probe = 0;
      n_fail = 0;
      num_checks = 0;
      repeat (8) @(posedge mclk);
      chk(led_bits, 12'h000);
      rst_n <= 1'b1;
      // steady power colours
      for (i = 0; i < 6; i++) begin
         set_mode(sm[i]);
         repeat (3) begin
            repeat (7) @(posedge mclk);
            chk(12'(led_bits[11:10]), 12'(sp[i]));
         end
      end
      // blink and waver timing
      for (i = 0; i < 15; i++) begin
         set_mode(cm[i]);
         measure(cb[i], ch[i]);
      end
      // bus status: flashes, error passive, overrun latch
      set_mode(14'h3000);
      for (i = 0; i < 6; i++) flash(i % 5, i[0]);
      ch_evt.err_passive[3] <= 1'b1;
      measure(3, FA);
      ch_evt.err_passive <= '0;
      ch_evt.overrun_evt[0] <= 1'b1;
      @(posedge mclk);
      ch_evt.overrun_evt <= '0;
      repeat (3) @(posedge mclk);
      lit = 0;
      repeat (30) begin
         @(posedge mclk);
         lit += led_bits[0];
      end
      chk(12'(lit), 12'h01E);
      ch_evt.bus_off[0] <= 1'b1;
      @(posedge mclk);
      ch_evt.bus_off <= '0;
      repeat (4) @(posedge mclk);
      chk(led_bits, 12'h800);
      // running pattern: order and dwell
      set_mode(14'h3100);
      repeat (2) @(posedge mclk);
      d = 0;
      while (led_bits !== 12'h800 && d < 200) begin
         @(posedge mclk);
         d++;
      end
      for (s = 1; s <= 13; s++) begin
         cur = led_bits;
         d = 0;
         while (led_bits === cur && d < 50) begin
            @(posedge mclk);
            d++;
         end
         chk(led_bits, 12'h001 << step_bit(s % 12));
         if (s > 1) chk(12'(d), 12'(RU));
      end
      // script override on power and one traffic led
      set_mode(14'h3000);
      script <= {1'b1, 5'h10, 12'h410};   // power yellow, traffic 4 red
      repeat (3) @(posedge mclk);
      chk(led_bits, 12'h410);
      script <= '0;
      repeat (3) @(posedge mclk);
      chk(led_bits, 12'h800);
      print_verdict;
   end
endmodule
